// file: src/tgd_gate_ctrl.sv
// Gate command logic of one buck power stage phase.
// Assumes analog comparators deliver clean synchronous levels on sense_in and phase_cmd_in.
`timescale 1ns/100ps
module tgd_gate_ctrl
  import tgd_pkg::*;
#(
  parameter int HOLDOFF_TICKS = HOLDOFF_CYCLES,
  parameter int BLANK_TICKS   = BLANK_CYCLES,
  parameter int DEAD_TICKS    = DEAD_CYCLES,
  parameter int TICK_DIVIDE   = TICK_DIV
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  // Controller side
  input  wire tgd_cmd_t   phase_cmd_in,
  input  wire logic       shutdown_n_in,
  input  wire logic       shutdown_n_driven_in,
  input  wire logic       zero_cross_mode_n_in,
  // Analog sense levels
  input  wire tgd_sense_t sense_in,
  // Gate commands
  output tgd_gate_t       gate_out,
  // Thermal warning open-drain pin
  output logic            thermal_warn_n_out,
  output logic            thermal_warn_n_oe_out
);

  // ==========================================================================
  // Timing tick
  // ==========================================================================
  logic [CNT_W-1:0] div_q;
  logic             tick;

  assign tick = (div_q == CNT_ZERO);

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in || tick)
      div_q <= CNT_W'(TICK_DIVIDE - 1);
    else
      div_q <= div_q - CNT_ONE;
  end

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == '1) ? v : v + CNT_ONE;
  endfunction : sat_inc

  // ==========================================================================
  // Supply lockout and enable
  // ==========================================================================
  logic lockout_q;
  logic lockout_d;
  logic shut_active;
  logic drive_en;

  // Comparator hysteresis: on and off thresholds differ, state holds between
  assign lockout_d   = sense_in.supply_below_off ? 1'b1 :
                       sense_in.supply_above_on  ? 1'b0 : lockout_q;
  // The pad pull-down makes an open pin read as shutdown
  assign shut_active = !(shutdown_n_in && shutdown_n_driven_in);
  assign drive_en    = !lockout_q && !shut_active;

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      lockout_q <= 1'b1;
    else
      lockout_q <= lockout_d;
  end

  // ==========================================================================
  // Tri-state hold-off
  // ==========================================================================
  logic [CNT_W-1:0] tri_cnt_q;
  logic             tri_expired;

  assign tri_expired = (tri_cnt_q >= CNT_W'(HOLDOFF_TICKS));

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in || phase_cmd_in != CMD_MID)
      tri_cnt_q <= CNT_ZERO;
    else if (tick)
      tri_cnt_q <= sat_inc(tri_cnt_q);
  end

  // ==========================================================================
  // Gate sequencer
  // ==========================================================================
  tgd_state_t       state_q;
  tgd_state_t       state_d;
  logic [CNT_W-1:0] dwell_q;
  logic             want_high;
  logic             want_low;
  logic             dead_done;
  logic             blank_done;
  logic             zc_enabled;
  tgd_gate_t        gate_d;

  assign want_high  = (phase_cmd_in == CMD_HIGH);
  assign want_low   = (phase_cmd_in == CMD_LOW);
  assign dead_done  = (dwell_q >= CNT_W'(DEAD_TICKS));
  assign blank_done = (dwell_q >= CNT_W'(BLANK_TICKS));
  assign zc_enabled = !zero_cross_mode_n_in;

  always_comb
  begin
    state_d = state_q;
    if (!drive_en || tri_expired)
      state_d = ST_IDLE;
    else
      case (state_q)
        ST_IDLE:
        begin
          if (want_high)
            state_d = ST_HS_WAIT;
          else if (want_low)
            state_d = ST_LS_WAIT;
        end
        ST_HS_WAIT:
        begin
          if (want_low)
            state_d = ST_LS_WAIT;
          else if (sense_in.low_gate_low && dead_done)
            state_d = ST_HS_ON;
        end
        ST_HS_ON:
        begin
          if (want_low)
            state_d = ST_LS_WAIT;
        end
        ST_LS_WAIT:
        begin
          if (want_high)
            state_d = ST_HS_WAIT;
          else if (sense_in.high_gate_low && dead_done)
            state_d = ST_LS_ON;
        end
        ST_LS_ON:
        begin
          if (want_high)
            state_d = ST_HS_WAIT;
          else if (zc_enabled && blank_done && sense_in.zero_cross_detect)
            state_d = ST_LS_DONE;
        end
        ST_LS_DONE:
        begin
          if (want_high)
            state_d = ST_HS_WAIT;
        end
        default:
          state_d = ST_IDLE;
      endcase
  end

  // One-hot decode of the state keeps the two gates exclusive by construction
  assign gate_d.high_gate_drive = (state_d == ST_HS_ON);
  assign gate_d.low_gate_drive  = (state_d == ST_LS_ON);

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      state_q  <= ST_IDLE;
      gate_out <= '0;
    end
    else
    begin
      state_q  <= state_d;
      gate_out <= gate_d;
    end
  end

  // Dwell restarts on every state change; blanking and dead time share it
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in || state_d != state_q)
      dwell_q <= CNT_ZERO;
    else if (tick)
      dwell_q <= sat_inc(dwell_q);
  end

  // ==========================================================================
  // Thermal warning
  // ==========================================================================
  logic warn_q;

  // The flag feeds only the pin; switching ignores it
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      warn_q <= 1'b0;
    else if (sense_in.temp_above_set)
      warn_q <= 1'b1;
    else if (sense_in.temp_below_clear)
      warn_q <= 1'b0;
  end

  assign thermal_warn_n_out    = 1'b0;
  assign thermal_warn_n_oe_out = warn_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_hs_turn_on;
    !gate_out.high_gate_drive ##1 gate_out.high_gate_drive;
  endsequence

  sequence s_ls_turn_on;
    !gate_out.low_gate_drive ##1 gate_out.low_gate_drive;
  endsequence

  property p_no_overlap;
    @(posedge clock_in) disable iff (!rst_b_in)
      !(gate_out.high_gate_drive && gate_out.low_gate_drive);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both gates on");

  property p_shutdown_off;
    @(posedge clock_in) disable iff (!rst_b_in)
      shut_active |=> (gate_out == '0);
  endproperty
  a_shutdown_off: assert property (p_shutdown_off) else $error("gate on in shutdown");

  property p_lockout_off;
    @(posedge clock_in) disable iff (!rst_b_in)
      sense_in.supply_below_off |=> ##1 (gate_out == '0);
  endproperty
  a_lockout_off: assert property (p_lockout_off) else $error("gate on in lockout");

  property p_holdoff_off;
    @(posedge clock_in) disable iff (!rst_b_in)
      tri_expired |=> (gate_out == '0);
  endproperty
  a_holdoff_off: assert property (p_holdoff_off) else $error("gate on after hold-off");

  property p_hs_dead_time;
    @(posedge clock_in) disable iff (!rst_b_in)
      s_hs_turn_on |-> $past(sense_in.low_gate_low) && $past(state_q) == ST_HS_WAIT;
  endproperty
  a_hs_dead_time: assert property (p_hs_dead_time) else $error("high on too early");

  property p_ls_dead_time;
    @(posedge clock_in) disable iff (!rst_b_in)
      s_ls_turn_on |-> $past(sense_in.high_gate_low) && !$past(gate_out.high_gate_drive);
  endproperty
  a_ls_dead_time: assert property (p_ls_dead_time) else $error("low on too early");

  property p_zc_release;
    @(posedge clock_in) disable iff (!rst_b_in)
      (state_q == ST_LS_ON && zc_enabled && blank_done && sense_in.zero_cross_detect)
      |=> !gate_out.low_gate_drive;
  endproperty
  a_zc_release: assert property (p_zc_release) else $error("low stayed on at zero");

  property p_forced_hold;
    @(posedge clock_in) disable iff (!rst_b_in)
      (gate_out.low_gate_drive && !zc_enabled && want_low && drive_en)
      |=> gate_out.low_gate_drive;
  endproperty
  a_forced_hold: assert property (p_forced_hold) else $error("low dropped in forced mode");

  property p_warn_hyst;
    @(posedge clock_in) disable iff (!rst_b_in)
      (warn_q && !sense_in.temp_below_clear) |=> thermal_warn_n_oe_out;
  endproperty
  a_warn_hyst: assert property (p_warn_hyst) else $error("warning cleared early");

  property p_warn_set;
    @(posedge clock_in) disable iff (!rst_b_in)
      sense_in.temp_above_set |=> thermal_warn_n_oe_out && !thermal_warn_n_out;
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("warning not set");

endmodule : tgd_gate_ctrl

// file: inc/tgd_pkg.sv
// Package for the tri-state gate drive control block.
// Assumes a single 25 MHz clock. All pin inputs are already synchronous digital levels.
package tgd_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS   = 40;
  localparam int HOLDOFF_TIME_NS = 130;
  localparam int DEAD_TIME_NS    = 10;
  // Least times round up to whole cycles; only the dead time is held to at least one cycle
  localparam int HOLDOFF_CYCLES  = (HOLDOFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_CYCLES_RAW = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_CYCLES     = (DEAD_CYCLES_RAW < 1) ? 1 : DEAD_CYCLES_RAW;
  localparam int BLANK_CYCLES    = 2;
  localparam int TICK_DIV        = 1;
  localparam int CNT_W           = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;

  // ==========================================================================
  // Phase command levels from the input comparators
  // ==========================================================================
  typedef enum logic [1:0] {
    CMD_LOW  = 2'b00,
    CMD_HIGH = 2'b01,
    CMD_MID  = 2'b10
  } tgd_cmd_t;

  // ==========================================================================
  // Gate sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_HS_WAIT = 3'b001,
    ST_HS_ON   = 3'b010,
    ST_LS_WAIT = 3'b011,
    ST_LS_ON   = 3'b100,
    ST_LS_DONE = 3'b101
  } tgd_state_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic supply_above_on;    // Logic supply above lockout on threshold
    logic supply_below_off;   // Logic supply below lockout off threshold
    logic temp_above_set;     // Junction above thermal_set_temp
    logic temp_below_clear;   // Junction below thermal_clear_temp
    logic high_gate_low;      // Monitored high-side gate below 1 V
    logic low_gate_low;       // Monitored low-side gate below 1 V
    logic zero_cross_detect;  // Inductor current has reached zero
  } tgd_sense_t;

  typedef struct packed {
    logic high_gate_drive;
    logic low_gate_drive;
  } tgd_gate_t;

endpackage : tgd_pkg

// file: verification/tgd_ctrl_model.sv
// Model of the regulator controller and the gate voltage monitors around the block.
// Assumes the bench changes its requests just after a falling clock edge.
`timescale 1ns/100ps
module tgd_ctrl_model
  import tgd_pkg::*;
(
  // Clock and requests
  input  wire logic      clock_in,
  input  wire logic      drive_en_in,
  input  wire logic      drive_level_in,
  input  wire logic      slow_in,
  // Gate feedback and outputs
  input  wire tgd_gate_t gate_in,
  output tgd_cmd_t       phase_cmd_out,
  output logic           high_gate_low_out,
  output logic           low_gate_low_out
);
  tgd_gate_t d1_q;
  tgd_gate_t d2_q;

  // ==========================================================================
  // Phase command
  // ==========================================================================
  // A released output floats into the mid band
  assign phase_cmd_out = !drive_en_in ? CMD_MID : (drive_level_in ? CMD_HIGH : CMD_LOW);

  // ==========================================================================
  // Gate monitors
  // ==========================================================================
  // A slow discharge keeps the monitor high for two more cycles after turn-off
  assign high_gate_low_out = !(gate_in.high_gate_drive
                               || (slow_in && (d1_q.high_gate_drive || d2_q.high_gate_drive)));
  assign low_gate_low_out  = !(gate_in.low_gate_drive
                               || (slow_in && (d1_q.low_gate_drive || d2_q.low_gate_drive)));

  always_ff @(posedge clock_in)
  begin
    d1_q <= gate_in;
    d2_q <= d1_q;
  end
endmodule : tgd_ctrl_model

// file: verification/tb_tristate_gate_drive_control.sv
// Self-checking bench for the gate drive control block.
// Assumes tgd_ctrl_model as the controller and a pull-up on the warning pin.
`timescale 1ns/100ps
module tb_tristate_gate_drive_control
  import tgd_pkg::*;
;
  logic       clock_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic       shutdown_n, shutdown_driven, zc_mode_n, drive_en, drive_level, slow;
  logic       above_on, below_off, temp_set, temp_clear, zero_detect;
  logic       high_low, low_low, warn_n, warn_oe, warn_pin, lvl;
  logic       pin_exp = 1'b1;
  logic       pin_new;
  logic [1:0] g_exp = 2'b10;
  logic [1:0] g_new;
  logic [1:0] g_mid;
  tgd_cmd_t   phase_cmd;
  tgd_gate_t  gate;
  tgd_sense_t sense;
  logic [2:0] exp_q[$];
  logic [2:0] last_q = 3'b100;
  int         n_errors = 0;
  int         n_compared = 0;
  int         seed = 32'h3ba132ef;
  int         r;

  always #20 clock_in = ~clock_in;
  assign sense    = {above_on, below_off, temp_set, temp_clear, high_low, low_low, zero_detect};
  assign warn_pin = warn_oe ? warn_n : 1'b1;

  tgd_gate_ctrl dut (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .phase_cmd_in(phase_cmd),
    .shutdown_n_in(shutdown_n), .shutdown_n_driven_in(shutdown_driven),
    .zero_cross_mode_n_in(zc_mode_n), .sense_in(sense), .gate_out(gate),
    .thermal_warn_n_out(warn_n), .thermal_warn_n_oe_out(warn_oe));

  tgd_ctrl_model u_ctrl (
    .clock_in(clock_in), .drive_en_in(drive_en), .drive_level_in(drive_level),
    .slow_in(slow), .gate_in(gate), .phase_cmd_out(phase_cmd),
    .high_gate_low_out(high_low), .low_gate_low_out(low_low));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask : step

  task automatic cmd(input logic en, input logic level, input int n);
    drive_en = en;
    drive_level = level;
    step(n);
  endtask : cmd

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Watcher: every change of {warning pin, gates} takes the oldest note
  // ==========================================================================
  always @(negedge clock_in)
    if (rst_b_in && {warn_pin, gate} !== last_q)
    begin
      last_q = {warn_pin, gate};
      if (exp_q.size() == 0)
        check("unexpected output change", last_q, 3'bxxx);
      else
        check("warn pin and gates", last_q, exp_q.pop_front());
    end

  initial
  begin
    #(40 * 5000);
    n_errors++;
    complete_run();
  end

  // ==========================================================================
  // Stimulus
  // ==========================================================================
  initial
  begin
    shutdown_n = 1'b1;
    shutdown_driven = 1'b1;
    zc_mode_n = 1'b1;
    drive_en = 1'b0;
    drive_level = 1'b0;
    slow = 1'b0;
    above_on = 1'b1;
    below_off = 1'b0;
    temp_set = 1'b0;
    temp_clear = 1'b1;
    zero_detect = 1'b0;
    step(10);
    rst_b_in = 1'b1;
    step(2);
    exp_q.push_back(3'b110);
    cmd(1, 1, 10);
    exp_q.push_back(3'b100);
    exp_q.push_back(3'b101);
    cmd(1, 0, 10);
    cmd(0, 0, 2);
    cmd(1, 0, 4);
    exp_q.push_back(3'b100);
    cmd(0, 0, 10);
    $display("test command levels done");
    exp_q.push_back(3'b000);
    temp_set = 1'b1;
    temp_clear = 1'b0;
    step(3);
    temp_set = 1'b0;
    step(3);
    exp_q.push_back(3'b010);
    cmd(1, 1, 10);
    exp_q.push_back(3'b110);
    temp_clear = 1'b1;
    step(4);
    $display("test thermal warning done");
    zc_mode_n = 1'b0;
    exp_q.push_back(3'b100);
    exp_q.push_back(3'b101);
    cmd(1, 0, 10);
    exp_q.push_back(3'b100);
    zero_detect = 1'b1;
    step(4);
    zero_detect = 1'b0;
    exp_q.push_back(3'b110);
    cmd(1, 1, 10);
    exp_q.push_back(3'b100);
    exp_q.push_back(3'b101);
    cmd(1, 0, 10);
    exp_q.push_back(3'b100);
    cmd(0, 0, 10);
    // Detector already high: the low side must still ride out the blanking delay
    zero_detect = 1'b1;
    exp_q.push_back(3'b101);
    exp_q.push_back(3'b100);
    cmd(1, 0, 5);
    check("low side during blanking", {1'b1, gate}, 3'b101);
    step(5);
    zero_detect = 1'b0;
    zc_mode_n = 1'b1;
    $display("test zero cross done");
    exp_q.push_back(3'b110);
    cmd(1, 1, 10);
    exp_q.push_back(3'b100);
    shutdown_n = 1'b0;
    step(4);
    exp_q.push_back(3'b110);
    shutdown_n = 1'b1;
    step(10);
    exp_q.push_back(3'b100);
    shutdown_driven = 1'b0;
    step(4);
    exp_q.push_back(3'b110);
    shutdown_driven = 1'b1;
    step(10);
    $display("test shutdown done");
    exp_q.push_back(3'b100);
    below_off = 1'b1;
    step(4);
    below_off = 1'b0;
    above_on = 1'b0;
    step(6);
    exp_q.push_back(3'b110);
    above_on = 1'b1;
    step(10);
    $display("test supply lockout done");
    // Random levels, shutdown and temperature with slow monitors and a noisy detector
    for (int i = 0; i < 24; i++)
    begin
      r = $random(seed);
      lvl = r[0];
      slow = r[1];
      zero_detect = r[2];
      // A warned controller is likelier to shut the phase down
      shutdown_n = r[3] | (warn_pin & r[7]);
      shutdown_driven = r[4] | r[8];
      temp_set = r[5] & r[9];
      temp_clear = r[6];
      pin_new = temp_set ? 1'b0 : (temp_clear ? 1'b1 : pin_exp);
      g_new = !(shutdown_n && shutdown_driven) ? 2'b00 : (lvl ? 2'b10 : 2'b01);
      // A gate change first passes through both off; the warning moves at the same edge
      g_mid = (g_new != g_exp) ? 2'b00 : g_exp;
      if ({pin_new, g_mid} != {pin_exp, g_exp})
        exp_q.push_back({pin_new, g_mid});
      if (g_new != g_mid)
        exp_q.push_back({pin_new, g_new});
      pin_exp = pin_new;
      g_exp = g_new;
      cmd(1, lvl, 12);
    end
    step(4);
    check("pending notes", {2'b00, exp_q.size() != 0}, 3'b000);
    $display("test random levels done");
    complete_run();
  end
endmodule : tb_tristate_gate_drive_control
